// ===== design/serial_irq_slave.sv
// serial interrupt slave: reports fifteen levels over the shared line
// assumes serirq_in is the resolved line level, synchronous to clk_sys,
// and that the host runs start and stop frames as the protocol defines
module serial_irq_slave (
  input  wire logic        clk_sys,       // bus clock, rising edges only
  input  wire logic        resetn,        // bus reset, active low, async
  input  wire logic [15:1] irq_level,     // internal interrupt levels
  input  wire logic        serirq_in,     // level seen on the serial line
  output logic             serirq_out,    // value driven when enabled
  output logic             serirq_oe,     // high while driving the line
  output logic             quiet_mode,    // mode of the current cycle
  output logic             cycle_active   // start to stop frame in progress
);

  // reset synchroniser
  logic                 rst_meta_reg;
  logic                 rst_n_reg;
  // captured levels
  logic [15:1]          lvl;
  logic [15:1]          chg;
  // cycle tracking
  serirq_pkg::state_t   state_reg;
  serirq_pkg::state_t   state_next;
  logic [5:0]           cnt_reg;
  logic [5:0]           cnt_next;
  logic [2:0]           low_run_reg;
  logic [2:0]           low_run_next;
  logic                 stop_seen;
  logic                 stop_quiet;
  logic                 mode_quiet_reg;
  // line drive
  logic                 oe_reg;
  logic                 oe_next;
  logic                 out_reg;
  logic                 out_next;
  logic                 req_drive_reg;
  logic                 req_next;
  logic                 drove_low_reg;
  logic                 drove_low_next;
  logic                 active_reg;
  // pending changes
  logic [15:1]          pend_reg;
  logic [15:1]          pend_clr;

  // sample clock of the frame carrying interrupt k
  function automatic logic [5:0] slot_of(input int k);
    slot_of = 6'(serirq_pkg::FRAME_LEN * k + serirq_pkg::FIRST_SAMPLE);
  endfunction : slot_of

  // reset asserts at once, releases after two edges
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // per-line capture
  irq_capture #(
    .WIDTH       (serirq_pkg::IRQ_COUNT),
    .RESET_LEVEL (serirq_pkg::LEVEL_RESET)
  ) u_capture (
    .clk_sys (clk_sys),
    .rst_n   (rst_n_reg),
    .irq_in  (irq_level),
    .level   (lvl),
    .changed (chg)
  );

  // cycle tracking from the sampled line
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    low_run_next = low_run_reg;
    stop_seen    = 1'b0;
    stop_quiet   = 1'b0;
    case (state_reg)
      serirq_pkg::ST_IDLE: begin
        if (!serirq_in) begin
          state_next = serirq_pkg::ST_START;
        end
      end
      serirq_pkg::ST_HOLD: begin
        // one clock after the stop rising edge
        if (!serirq_in) begin
          state_next = serirq_pkg::ST_START;
        end else begin
          state_next = serirq_pkg::ST_IDLE;
        end
      end
      serirq_pkg::ST_START: begin
        // the host stretches the pulse; wait for its rising edge
        if (serirq_in) begin
          state_next   = serirq_pkg::ST_FRAMES;
          cnt_next     = serirq_pkg::CNT_ONE;
          low_run_next = serirq_pkg::LOW_ZERO;
        end
      end
      serirq_pkg::ST_FRAMES: begin
        if (cnt_reg != serirq_pkg::CNT_MAX) begin
          cnt_next = cnt_reg + serirq_pkg::CNT_ONE;
        end
        if (!serirq_in) begin
          if (low_run_reg != serirq_pkg::LOW_MAX) begin
            low_run_next = low_run_reg + serirq_pkg::LOW_ONE;
          end
        end else begin
          low_run_next = serirq_pkg::LOW_ZERO;
          // data frames are one clock low; two or more is a stop
          if (low_run_reg >= serirq_pkg::STOP_QUIET_LOW) begin
            stop_seen  = 1'b1;
            stop_quiet = (low_run_reg == serirq_pkg::STOP_QUIET_LOW);
            state_next = serirq_pkg::ST_HOLD;
          end
        end
      end
      default: begin
        state_next = serirq_pkg::ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg   <= serirq_pkg::ST_IDLE;
      cnt_reg     <= 6'h00;
      low_run_reg <= 3'h0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      low_run_reg <= low_run_next;
    end
  end

  // mode register, updated only by a stop frame
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mode_quiet_reg <= serirq_pkg::MODE_RESET;
    end else if (stop_seen) begin
      mode_quiet_reg <= stop_quiet;
    end
  end

  // line drive for the coming clock
  always_comb begin
    oe_next  = 1'b0;
    out_next = 1'b1;
    req_next = 1'b0;
    if (state_next == serirq_pkg::ST_FRAMES) begin
      if (drove_low_reg) begin
        oe_next  = 1'b1;
        out_next = 1'b1;
      end else begin
        for (int k = 1; k <= serirq_pkg::IRQ_COUNT; k++) begin
          if ((cnt_next == slot_of(k)) && !lvl[k]) begin
            oe_next  = 1'b1;
            out_next = 1'b0;
          end
        end
      end
    end else if ((state_reg == serirq_pkg::ST_IDLE) &&
                 (state_next == serirq_pkg::ST_IDLE) &&
                 mode_quiet_reg && (|pend_reg) && !req_drive_reg) begin
      req_next = 1'b1;
      oe_next  = 1'b1;
      out_next = 1'b0;
    end
    drove_low_next = (state_next == serirq_pkg::ST_FRAMES) && oe_next && !out_next;
  end

  // drive registers; turn-around falls out as release
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      oe_reg        <= 1'b0;
      out_reg       <= 1'b1;
      req_drive_reg <= 1'b0;
      drove_low_reg <= 1'b0;
    end else begin
      oe_reg        <= oe_next;
      out_reg       <= out_next;
      req_drive_reg <= req_next;
      drove_low_reg <= drove_low_next;
    end
  end

  // frames whose sample clock comes at the next edge
  always_comb begin
    pend_clr = '0;
    for (int k = 1; k <= serirq_pkg::IRQ_COUNT; k++) begin
      pend_clr[k] = (state_next == serirq_pkg::ST_FRAMES) && (cnt_next == slot_of(k));
    end
  end

  // changes not yet delivered; a new change wins over delivery
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | chg;
    end
  end

  // status of the current cycle
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= (state_next == serirq_pkg::ST_START) ||
                    (state_next == serirq_pkg::ST_FRAMES);
    end
  end

  assign serirq_out   = out_reg;
  assign serirq_oe    = oe_reg;
  assign quiet_mode   = mode_quiet_reg;
  assign cycle_active = active_reg;

  // a start request lasts one clock and is then released
  start_one_clk_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    req_drive_reg |-> !serirq_out ##1 (!req_drive_reg && !serirq_oe)
  ) else $error("start request not a single low clock");

  // a start request is only made from an idle line
  req_only_idle_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    $rose(req_drive_reg) |-> $past(state_reg == serirq_pkg::ST_IDLE) && !active_reg
  ) else $error("start request during an active cycle");

  // no request in continuous mode
  cont_passive_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    req_drive_reg |-> mode_quiet_reg
  ) else $error("start request in continuous mode");

  // pending change in quiet mode on an idle line raises a request
  quiet_request_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_IDLE) && serirq_in && mode_quiet_reg &&
    (|pend_reg) && !req_drive_reg |=> req_drive_reg && serirq_oe
  ) else $error("pending change did not raise a request");

  // mode only changes right after a stop frame
  mode_at_stop_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    $changed(mode_quiet_reg) |-> state_reg == serirq_pkg::ST_HOLD
  ) else $error("mode changed outside a stop frame");

  // two low clocks select quiet, three continuous
  stop_quiet_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_FRAMES) && serirq_in &&
    (low_run_reg == serirq_pkg::STOP_QUIET_LOW) |=> mode_quiet_reg
  ) else $error("two clock stop did not select quiet");

  stop_cont_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_FRAMES) && serirq_in &&
    (low_run_reg == serirq_pkg::STOP_CONT_LOW) |=> !mode_quiet_reg
  ) else $error("three clock stop did not select continuous");

  // counting starts on the rising edge of the start pulse
  count_start_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_START) && serirq_in |=>
    (state_reg == serirq_pkg::ST_FRAMES) && (cnt_reg == 6'h01)
  ) else $error("frame count did not start at the rising edge");

  // low, then high, then released
  frame_phases_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_FRAMES) && serirq_oe && !serirq_out &&
    (state_next == serirq_pkg::ST_FRAMES) |=> serirq_oe && serirq_out ##1 !serirq_oe
  ) else $error("recovery or turn-around clock wrong");

  // recovery high only after own sample low
  recovery_cause_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    serirq_oe && serirq_out |-> $past(serirq_oe) && !$past(serirq_out)
  ) else $error("line driven high without a preceding low");

  // low drive in frames only on sample clocks 5 to 47
  sample_slot_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_FRAMES) && serirq_oe && !serirq_out |->
    ((cnt_reg % serirq_pkg::FRAME_LEN) == serirq_pkg::FIRST_SAMPLE) &&
    (cnt_reg >= slot_of(1)) && (cnt_reg <= slot_of(serirq_pkg::IRQ_COUNT))
  ) else $error("low drive outside a sample clock");

  // interrupt 1 sampled at clock 5 from its captured level
  irq1_sample_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == serirq_pkg::ST_FRAMES) && (cnt_reg == slot_of(1)) |->
    (serirq_oe == !$past(lvl[1])) && (!serirq_oe || !serirq_out)
  ) else $error("interrupt 1 sample drive wrong");

  // no start within one clock of the stop rising edge
  stop_holdoff_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n_reg)
    state_reg == serirq_pkg::ST_HOLD |-> !serirq_oe ##1 !serirq_oe
  ) else $error("line driven too soon after stop");

  // released throughout reset
  reset_release_a: assert property (
    @(posedge clk_sys) !rst_n_reg |-> !serirq_oe && !quiet_mode
  ) else $error("line driven during reset");

endmodule : serial_irq_slave

// ===== design/serirq_pkg.sv
// constants and types shared by the serial interrupt slave
// assumes one bus clock; the serial line is resolved outside from oe and out
//
// Notes on behaviour
// - quiet request drives line low one clock, then releases, never high.
// - no start request while a serial cycle is active.
// - quiet mode: an undelivered level change raises a start request.
// - continuous mode: only host starts cycles; slave stays passive.
// - mode changes only in the stop frame; reset gives continuous.
// - slave measures every stop frame low width to pick next mode.
// - frame counting starts at rising edge ending the start pulse.
// - each data frame is sample, recovery, turn-around clocks.
// - sample clock drives low only when captured level is low.
// - recovery clock drives high only after driving low in sample.
// - turn-around clock always releases the line.
// - frame n sample falls 3n-1 clocks after start rising edge.
// - host stop: two low clocks quiet, three low clocks continuous.
// - new start no earlier than second clock after stop rising edge.
// - line driven and sampled only on rising clock edges.
// - line released during reset; reset gives continuous idle.
package serirq_pkg;

  // interrupt lines carried, numbered 1 to 15
  localparam int          IRQ_COUNT      = 15;
  // clocks per data frame
  localparam int          FRAME_LEN      = 3;
  // sample clock of frame 1, counted from the start rising edge
  localparam int          FIRST_SAMPLE   = 2;
  // frame counter width and its saturation value
  localparam int          CNT_W          = 6;
  localparam logic [5:0]  CNT_ONE        = 6'h01;
  localparam logic [5:0]  CNT_MAX        = 6'h3f;
  // consecutive low clocks seen on the line
  localparam logic [2:0]  LOW_ZERO       = 3'h0;
  localparam logic [2:0]  LOW_ONE        = 3'h1;
  localparam logic [2:0]  LOW_MAX        = 3'h7;
  // stop widths: two selects quiet, three or more continuous
  localparam logic [2:0]  STOP_QUIET_LOW = 3'h2;
  localparam logic [2:0]  STOP_CONT_LOW  = 3'h3;
  // reset values
  localparam logic        MODE_RESET     = 1'b0;  // continuous
  localparam logic        LEVEL_RESET    = 1'b1;  // lines read as inactive high

  // cycle tracking states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_START,
    ST_FRAMES,
    ST_HOLD
  } state_t;

endpackage : serirq_pkg

// ===== design/irq_capture.sv
// registers the interrupt levels and flags lines about to change
// assumes levels are synchronous to clk_sys
module irq_capture #(
  parameter int   WIDTH       = 15,
  parameter logic RESET_LEVEL = 1'b1
) (
  input  wire logic             clk_sys,  // bus clock
  input  wire logic             rst_n,    // synchronised reset, active low
  input  wire logic [WIDTH-1:0] irq_in,   // live levels
  output logic      [WIDTH-1:0] level,    // last captured levels
  output logic      [WIDTH-1:0] changed   // level differs from capture
);

  logic [WIDTH-1:0] level_reg;

  // capture every clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= {WIDTH{RESET_LEVEL}};
    end else begin
      level_reg <= irq_in;
    end
  end

  // change about to be captured at the coming edge
  assign level   = level_reg;
  assign changed = irq_in ^ level_reg;

endmodule : irq_capture

// ===== dv/serirq_host.sv
// host serial interrupt controller model: start, frame and stop timing
// assumes the line is pulled up and resolved in the bench from both enables
module serirq_host (
  input  wire logic clk_sys,    // bus clock
  input  wire logic serirq,     // resolved line level
  input  wire logic slave_oe,   // slave drive enable
  input  wire logic slave_out,  // slave drive value
  output logic      host_oe,    // host drive enable
  output logic      host_out    // host drive value
);
  timeunit 1ns;
  timeprecision 1ps;

  // released during reset and between cycles
  initial begin
    host_oe  = 1'b0;
    host_out = 1'b1;
  end

  // one clock of host drive, changed just after the rising edge
  task automatic drive(input logic oe, input logic v);
    @(posedge clk_sys);
    #1;
    host_oe  = oe;
    host_out = v;
  endtask : drive

  // count idle high clocks until a low request shows, up to limit
  task automatic wait_req(input int limit, output int n);
    n = 0;
    @(negedge clk_sys);
    while (serirq === 1'b1 && n < limit) begin
      n++;
      @(negedge clk_sys);
    end
  endtask : wait_req

  // one cycle: start stretch, seventeen frames, stop of stop_n low clocks;
  // flags slave drive in the start low and frame clocks outside its sample and recovery slots
  task automatic run_cycle(input int low_n, input int stop_n,
                           output logic [16:0] seen, output int errs);
    int   c;
    logic drv;
    errs = 0;
    drv  = 1'b0;
    seen = '0;
    // host owns the start low; the slave must be off by now
    repeat (low_n) begin
      drive(1'b1, 1'b0);
      @(negedge clk_sys);
      if (slave_oe === 1'b1) errs++;
    end
    drive(1'b1, 1'b1);
    for (c = 1; c <= 52; c++) begin
      drive(1'b0, 1'b1);
      @(negedge clk_sys);
      if (c % 3 == 2) seen[(c - 2) / 3] = serirq;
      if (slave_oe === 1'b1 && !((c % 3 == 2 && c >= 5 && c <= 47 && slave_out === 1'b0) ||
          (c % 3 == 0 && drv && slave_out === 1'b1))) errs++;
      if (drv && c % 3 == 0 && !(slave_oe === 1'b1 && slave_out === 1'b1)) errs++;
      drv = (slave_oe === 1'b1 && slave_out === 1'b0 && c % 3 == 2);
    end
    repeat (stop_n) drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    // idle clock before any new start
    drive(1'b0, 1'b1);
  endtask : run_cycle

endmodule : serirq_host

// ===== dv/tb_serial_irq_slave.sv
// testbench for the serial interrupt slave against a host model
// assumes a pulled-up shared line resolved here from both drive enables
module tb_serial_irq_slave;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys;
  logic        resetn;
  logic [15:1] irq_level;
  logic        serirq_out;
  logic        serirq_oe;
  logic        quiet_mode;
  logic        cycle_active;
  logic        host_oe;
  logic        host_out;
  wire logic   serirq_in;
  int          mismatches = 0;
  int          checks = 0;
  logic [16:0] seen;
  logic [15:1] lv;
  int          errs;
  int          n;

  // wired line with pull-up
  assign serirq_in = serirq_oe ? serirq_out : (host_oe ? host_out : 1'b1);

  serial_irq_slave i_dut (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .irq_level    (irq_level),
    .serirq_in    (serirq_in),
    .serirq_out   (serirq_out),
    .serirq_oe    (serirq_oe),
    .quiet_mode   (quiet_mode),
    .cycle_active (cycle_active)
  );

  serirq_host i_host (
    .clk_sys   (clk_sys),
    .serirq    (serirq_in),
    .slave_oe  (serirq_oe),
    .slave_out (serirq_out),
    .host_oe   (host_oe),
    .host_out  (host_out)
  );

  // 250 MHz bus clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // one host cycle, levels expected as l, then mode and idle state
  task automatic cycle_check(input int low_n, input int stop_n, input logic [15:1] l,
                             input logic q);
    i_host.run_cycle(low_n, stop_n, seen, errs);
    @(negedge clk_sys);
    check("frame levels", seen, {1'b1, l, 1'b1});
    check("drive slots", errs, 0);
    check("mode", quiet_mode, q);
    check("idle", cycle_active, 1'b0);
  endtask : cycle_check

  task automatic t_reset();
    resetn    = 1'b0;
    irq_level = 15'h7fff;
    repeat (3) @(negedge clk_sys);
    check("oe in reset", serirq_oe, 1'b0);
    resetn = 1'b1;
    repeat (6) @(negedge clk_sys);
    check("oe after reset", serirq_oe, 1'b0);
    check("mode after reset", quiet_mode, 1'b0);
    $display("done: reset");
  endtask : t_reset

  task automatic t_continuous();
    irq_level = 15'h2b6d;
    repeat (4) @(negedge clk_sys);
    cycle_check(4, 3, irq_level, 1'b0);
    $display("done: continuous cycle");
  endtask : t_continuous

  task automatic t_quiet_req();
    cycle_check(8, 2, irq_level, 1'b1);
    irq_level[3] = ~irq_level[3];
    i_host.wait_req(60, n);
    check("request seen", n < 60, 1'b1);
    check("request delay", n, 1);
    cycle_check(3, 2, irq_level, 1'b1);
    $display("done: quiet request");
  endtask : t_quiet_req

  // change lands after its slot: no start mid cycle, request after stop
  task automatic t_mid_change();
    lv = irq_level;
    fork
      cycle_check(4, 2, lv, 1'b1);
      begin
        repeat (30) @(negedge clk_sys);
        check("active mid cycle", cycle_active, 1'b1);
        irq_level[1] = ~irq_level[1];
      end
    join
    i_host.wait_req(60, n);
    check("request spacing", n, 1);
    check("late request", n < 60, 1'b1);
    cycle_check(3, 3, irq_level, 1'b0);
    $display("done: mid cycle change");
  endtask : t_mid_change

  task automatic t_passive();
    irq_level[15] = ~irq_level[15];
    i_host.wait_req(60, n);
    check("no request", n, 60);
    cycle_check(5, 3, irq_level, 1'b0);
    $display("done: continuous passive");
  endtask : t_passive

  // main sequence
  initial begin
    t_reset();
    t_continuous();
    t_quiet_req();
    t_mid_change();
    t_passive();
    give_verdict();
  end

  // watchdog well past the expected run of about 460 clocks
  initial begin
    #20000;
    mismatches++;
    $display("watchdog expired");
    give_verdict();
  end

endmodule : tb_serial_irq_slave
